/* design/bfd_fault_diag.sv */
// fault latching, flag output and read-only serial diagnosis of the bridge
`timescale 1ns/1ps
`include "bfd_cfg.svh"
module bfd_fault_diag import bfd_pkg::*; #(
  parameter int CNT_W = 5,
  parameter logic [7:0] ID_CODE = 8'h5a,   // arbitrary value
  parameter logic [7:0] REV_CODE = 8'h11   // arbitrary value
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sck,
  input wire logic csN,
  input wire logic sdi,
  output logic sdo,
  output logic sdoOe,
  input wire logic diagModeSelectPin,
  input wire logic outputOnInput,
  input wire logic outputOffInput,
  input wire logic underVoltDet,
  input wire logic overTempDet,
  input wire logic tempCurrRedDet,
  input wire logic currLimitDet,
  input wire logic overCurrDet,
  input wire logic openLoadDet,
  input wire logic hsShortDet,
  input wire logic lsShortDet,
  input wire logic [1:0] shortGndDet,
  input wire logic [1:0] shortBatDet,
  output logic faultFlagOut,
  output logic faultFlagOe,
  output logic outputsTristate,
  output logic loadShortFlag,
  output logic overTemperatureFlag,
  output logic underVoltFlag,
  output logic transferErrorFlag,
  output logic [7:0] faultRegister
);

  // ----------------------------------------------------------------
  // constants and checks
  // ----------------------------------------------------------------
  localparam int WIN_CYC = `BFD_LOAD_SHORT_FLAG_WIN_NS * `BFD_CLK_MHZ / 1000;
  localparam int WIN_W = $clog2(WIN_CYC + 1);
  localparam logic [CNT_W-1:0] FRAME_N = CNT_W'(`BFD_FRAME_BITS);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(`BFD_FRAME_BITS + 1);
  localparam logic [CNT_W-1:0] ADDR_N = CNT_W'(`BFD_ADDR_BITS);
  localparam logic [CNT_W-1:0] COMMAND_CODE_FIELD_N = CNT_W'(`BFD_COMMAND_CODE_FIELD_BITS);

  generate
    if (CNT_W < 5) begin : g_chk
      $error("CNT_W too narrow to tell 17 edges from 16");
    end
  endgenerate

  function automatic logic [1:0] outCode(input logic sg, input logic sb);
    return sb ? `BFD_OC_SCB : (sg ? `BFD_OC_SCG : `BFD_OC_OK);
  endfunction

  function automatic bfd_cmd_t decodeCmd(input logic [7:0] ins);
    bfd_cmd_t c;
    c = CMD_BAD;
    if (^ins[5:0] == 1'b0) begin
      case (ins[5:1])
        `BFD_OP_ID: c = CMD_ID;
        `BFD_OP_REV: c = CMD_REV;
        `BFD_OP_FAULT: c = CMD_FAULT;
        default: c = CMD_BAD;
      endcase
    end
    return c;
  endfunction

  function automatic logic [WIN_W-1:0] decSat(input logic [WIN_W-1:0] v);
    return (v != '0) ? v - 1'b1 : v;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic tagTgl_r;
  logic [16:0] inMeta_r, inSync_r;
  logic [6:0] edgePrev_r;
  logic csS, dmsS, enS, disS, uvS, otS, crS, clS, ocS, olS, hsS, lsS, tagS;
  logic [1:0] sgS, sbS;
  logic csP, dmsP, enP, disP, hsP, lsP, tagP;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      inMeta_r <= `BFD_SYNC_RST;
      inSync_r <= `BFD_SYNC_RST;
      edgePrev_r <= 7'h40;
    end else begin
      inMeta_r <= {csN, diagModeSelectPin, outputOnInput, outputOffInput, underVoltDet,
                   overTempDet, tempCurrRedDet, currLimitDet, overCurrDet, openLoadDet,
                   hsShortDet, lsShortDet, shortGndDet, shortBatDet, tagTgl_r};
      inSync_r <= inMeta_r;
      edgePrev_r <= {csS, dmsS, enS, disS, hsS, lsS, tagS};
    end
  end

  assign {csS, dmsS, enS, disS, uvS, otS, crS, clS, ocS, olS, hsS, lsS, sgS, sbS, tagS} =
    inSync_r;
  assign {csP, dmsP, enP, disP, hsP, lsP, tagP} = edgePrev_r;

  wire enRise = enS & ~enP;
  wire disFall = ~disS & disP;
  wire dmsRise = dmsS & ~dmsP;
  wire hsEv = hsS & ~hsP;
  wire lsEv = lsS & ~lsP;
  wire frameEnd = csS & ~csP & dmsS;
  wire offNow = ~enS | disS;

  // ----------------------------------------------------------------
  // load short window
  // ----------------------------------------------------------------
  logic [WIN_W-1:0] hsWin_r, lsWin_r;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hsWin_r <= '0;
      lsWin_r <= '0;
    end else begin
      hsWin_r <= hsEv ? WIN_W'(WIN_CYC) : decSat(hsWin_r);
      lsWin_r <= lsEv ? WIN_W'(WIN_CYC) : decSat(lsWin_r);
    end
  end

  // either order counts; equal arrival also counts
  wire loadShortEv = (hsEv & (lsEv | (lsWin_r != '0))) | (lsEv & (hsWin_r != '0));

  // ----------------------------------------------------------------
  // fault latches
  // ----------------------------------------------------------------
  logic [9:0] lat_r;
  logic fatal_r;
  logic [CNT_W-1:0] cntHold_r;
  logic addrHold_r, sckHigh_r;
  bfd_cmd_t cmdHold_r;
  logic tagSeen_r;

  wire gotEdges = tagS ^ tagSeen_r;
  wire [CNT_W-1:0] fCnt = gotEdges ? cntHold_r : '0;
  wire addrMatch = gotEdges & addrHold_r;
  wire sent = addrMatch & (fCnt >= COMMAND_CODE_FIELD_N);
  wire frameOk = fCnt == FRAME_N;
  // a frame cut before its address is known still counts as a bad transfer
  wire frameErr = (addrMatch | (fCnt < ADDR_N)) &
                  (~frameOk | sckHigh_r | (cmdHold_r == CMD_BAD));
  wire spiClr = frameEnd & addrMatch & frameOk & (cmdHold_r == CMD_FAULT);
  wire porClr = (~dmsS & uvS) | dmsRise;
  wire edgeClr = enRise | disFall;
  wire shutClr = porClr | edgeClr;
  wire faultClr = shutClr | spiClr;
  wire fatalEv = otS | ocS | loadShortEv | (|sgS) | (|sbS);
  wire [9:0] evVec = {otS, crS, clS, ocS, olS, loadShortEv, sgS, sbS};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lat_r <= '0;
      fatal_r <= 1'b0;
    end else begin
      lat_r <= evVec | (faultClr ? '0 : lat_r);
      fatal_r <= fatalEv | (shutClr ? 1'b0 : fatal_r);
    end
  end

  wire latOt = lat_r[9];
  wire latCr = lat_r[8];
  wire latCl = lat_r[7];
  wire latOl = lat_r[5];
  wire latScol = lat_r[4];
  wire [1:0] latSg = lat_r[3:2];
  wire [1:0] latSb = lat_r[1:0];

  // nibble priority: under-voltage, load short, output shorts, open load
  wire [3:0] shortNib = {outCode(latSg[1], latSb[1]), outCode(latSg[0], latSb[0])};
  wire [3:0] diaNib = uvS ? `BFD_NIB_UV :
                      latScol ? `BFD_NIB_LOAD_SHORT_FLAG :
                      ((|latSg) | (|latSb)) ? shortNib :
                      latOl ? `BFD_NIB_OL : `BFD_NIB_OK;
  wire [7:0] faultNow = {~offNow, ~latOt, ~latCr, ~latCl, diaNib};

  // ----------------------------------------------------------------
  // outputs of the clock domain
  // ----------------------------------------------------------------
  logic [7:0] faultSnap_r;
  wire shutNow = uvS | fatalEv | fatal_r | offNow;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      outputsTristate <= 1'b1;
      faultFlagOe <= 1'b0;
      faultRegister <= `BFD_FAULT_RST;
      faultSnap_r <= `BFD_FAULT_RST;
      loadShortFlag <= 1'b0;
      overTemperatureFlag <= 1'b0;
      underVoltFlag <= 1'b0;
    end else begin
      outputsTristate <= shutNow;
      faultFlagOe <= ~dmsS & shutNow;
      faultRegister <= faultNow;
      // held still while selected so the link side reads a steady word
      faultSnap_r <= csS ? faultRegister : faultSnap_r;
      loadShortFlag <= latScol;
      overTemperatureFlag <= latOt;
      underVoltFlag <= uvS;
    end
  end

  assign faultFlagOut = 1'b0;

  // ----------------------------------------------------------------
  // transfer error flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || !dmsS) begin
      transferErrorFlag <= 1'b0;
      tagSeen_r <= 1'b0;
    end else begin
      if (frameEnd) begin
        transferErrorFlag <= frameErr | (transferErrorFlag & ~sent);
        tagSeen_r <= tagS;
      end
    end
  end

  // ----------------------------------------------------------------
  // link side, clocked by the master
  // ----------------------------------------------------------------
  // frame logic is reset by chip select, so it never needs a clock outside frames
  wire frameRst = csN | ~dmsS;
  bfd_spi_st_t state_r;
  logic [7:0] shIn_r, dataByte_r;
  logic roseSeen_r, tefM_r, tefS_r;

  wire first = state_r == ST_WAIT;
  wire [CNT_W-1:0] cntNxt = first ? CNT_W'(1) :
                            (cntHold_r == CNT_MAX) ? cntHold_r : cntHold_r + 1'b1;
  wire [7:0] shNxt = {shIn_r[6:0], sdi};
  wire addrOk = shNxt[1:0] == `BFD_CHIP_ADDR;
  wire instrDone = cntNxt == COMMAND_CODE_FIELD_N;
  bfd_cmd_t cmdNxt;
  assign cmdNxt = decodeCmd(shNxt);
  wire [7:0] dataNxt = (cmdNxt == CMD_ID) ? ID_CODE :
                       (cmdNxt == CMD_REV) ? REV_CODE :
                       (cmdNxt == CMD_FAULT) ? faultSnap_r : `BFD_UNUSED_DATA;

  always_ff @(negedge sck or posedge frameRst) begin
    if (frameRst) begin
      state_r <= ST_WAIT;
      shIn_r <= '0;
      dataByte_r <= `BFD_UNUSED_DATA;
    end else begin
      case (state_r)
        ST_WAIT: begin
          state_r <= ST_ADDR;
          shIn_r <= shNxt;
        end
        ST_ADDR: begin
          shIn_r <= shNxt;
          if (cntNxt == ADDR_N) begin
            state_r <= addrOk ? ST_CMD : ST_IGNORE;
          end
        end
        ST_CMD: begin
          shIn_r <= shNxt;
          if (instrDone) begin
            state_r <= ST_DATA;
            dataByte_r <= dataNxt;
          end
        end
        // spare byte and foreign frames leave the shifter alone
        ST_DATA: state_r <= ST_DATA;
        ST_IGNORE: state_r <= ST_IGNORE;
        default: state_r <= ST_WAIT;
      endcase
    end
  end

  // frame summary survives chip select so the clock domain can judge it
  always_ff @(negedge sck or negedge dmsS) begin
    if (!dmsS) begin
      cntHold_r <= '0;
      addrHold_r <= 1'b0;
      cmdHold_r <= CMD_BAD;
      sckHigh_r <= 1'b0;
      tagTgl_r <= 1'b0;
    end else begin
      cntHold_r <= cntNxt;
      if (first) begin
        addrHold_r <= 1'b0;
        cmdHold_r <= CMD_BAD;
        sckHigh_r <= ~roseSeen_r;
        tagTgl_r <= ~tagTgl_r;
      end else begin
        if (state_r == ST_ADDR && cntNxt == ADDR_N) begin
          addrHold_r <= addrOk;
        end
        if (state_r == ST_CMD && instrDone) begin
          cmdHold_r <= cmdNxt;
        end
      end
    end
  end

  wire [CNT_W-1:0] fc = first ? '0 : cntHold_r;
  wire [7:0] verifWord = {2'h0, `BFD_VERIF_FIX, tefS_r};
  wire talking = (state_r == ST_CMD || state_r == ST_DATA) &&
                 (fc >= ADDR_N) && (fc < FRAME_N);
  wire bitNxt = fc[3] ? dataByte_r[~fc[2:0]] : verifWord[~fc[2:0]];

  always_ff @(posedge sck or posedge frameRst) begin
    if (frameRst) begin
      roseSeen_r <= 1'b0;
      tefM_r <= 1'b0;
      tefS_r <= 1'b0;
      sdo <= 1'b0;
      sdoOe <= 1'b0;
    end else begin
      roseSeen_r <= 1'b1;
      tefM_r <= transferErrorFlag;
      tefS_r <= tefM_r;
      sdo <= bitNxt;
      sdoOe <= talking;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_load_short_flag;
    @(posedge clk) disable iff (!nrst) (hsEv && lsWin_r != '0) |=> ##1 loadShortFlag;
  endproperty
  a_load_short_flag: assert property (p_load_short_flag) else $error("load short not flagged");

  property p_ot_off;
    @(posedge clk) disable iff (!nrst) otS |=> outputsTristate ##1 overTemperatureFlag;
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("over-temperature not handled");

  property p_uv_off;
    @(posedge clk) disable iff (!nrst) uvS |=> outputsTristate && underVoltFlag;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("under-voltage not handled");

  property p_sf_low;
    @(posedge clk) disable iff (!nrst) (!dmsS && (offNow || uvS || fatal_r)) |=> faultFlagOe;
  endproperty
  a_sf_low: assert property (p_sf_low) else $error("flag not pulled low");

  property p_sf_release;
    @(posedge clk) disable iff (!nrst)
      (!dmsS && !uvS && !fatal_r && !fatalEv && !offNow) |=> !faultFlagOe && !outputsTristate;
  endproperty
  a_sf_release: assert property (p_sf_release) else $error("flag not released");

  property p_por;
    @(posedge clk) disable iff (!nrst) (!dmsS && uvS && !fatalEv) |=> !fatal_r;
  endproperty
  a_por: assert property (p_por) else $error("under-voltage did not clear faults");

  property p_hold;
    @(posedge clk) disable iff (!nrst) (fatal_r && !shutClr) |=> fatal_r && outputsTristate;
  endproperty
  a_hold: assert property (p_hold) else $error("latched shutdown lost");

  property p_tef_set;
    @(posedge clk) disable iff (!nrst) (frameEnd && frameErr) |=> transferErrorFlag;
  endproperty
  a_tef_set: assert property (p_tef_set) else $error("transfer error not set");

  property p_tef_hold;
    @(posedge clk) disable iff (!nrst)
      (transferErrorFlag && dmsS && !(frameEnd && sent)) |=> transferErrorFlag;
  endproperty
  a_tef_hold: assert property (p_tef_hold) else $error("error flag dropped unsent");

  property p_fault_clr;
    @(posedge clk) disable iff (!nrst)
      (spiClr && evVec == '0) ##1 (evVec == '0) |=> faultRegister[6:4] == 3'h7;
  endproperty
  a_fault_clr: assert property (p_fault_clr) else $error("fault register not cleared");

  property p_ignore;
    @(posedge sck) disable iff (frameRst) (state_r == ST_IGNORE) |=> !sdoOe;
  endproperty
  a_ignore: assert property (p_ignore) else $error("drove data for foreign address");

endmodule

/* design/bfd_cfg.svh */
// configuration macros for the bridge fault diagnosis block
`ifndef BFD_CFG_SVH
`define BFD_CFG_SVH
`define BFD_CLK_MHZ 25
`define BFD_LOAD_SHORT_FLAG_WIN_NS 2000
`define BFD_FRAME_BITS 16
`define BFD_ADDR_BITS 2
`define BFD_COMMAND_CODE_FIELD_BITS 8
`define BFD_CHIP_ADDR 2'h0
`define BFD_OP_ID 5'h00
`define BFD_OP_REV 5'h01
`define BFD_OP_FAULT 5'h04
`define BFD_VERIF_FIX 5'h15
`define BFD_FAULT_RST 8'hff
`define BFD_UNUSED_DATA 8'hff
`define BFD_NIB_UV 4'h0
`define BFD_NIB_LOAD_SHORT_FLAG 4'hc
`define BFD_NIB_OL 4'h3
`define BFD_NIB_OK 4'hf
`define BFD_OC_SCB 2'h1
`define BFD_OC_SCG 2'h2
`define BFD_OC_OK 2'h3
`define BFD_SYNC_RST 17'h10000
`endif

/* design/bfd_pkg.sv */
// types shared by the bridge fault diagnosis block
package bfd_pkg;
  typedef enum logic [2:0] {ST_WAIT, ST_ADDR, ST_CMD, ST_DATA, ST_IGNORE} bfd_spi_st_t;
  typedef enum logic [1:0] {CMD_ID, CMD_REV, CMD_FAULT, CMD_BAD} bfd_cmd_t;
endpackage

/* dv/bfd_spi_master.sv */
// serial master model that drives frames onto the diagnosis link
`timescale 1ns/1ps
module bfd_spi_master (
  output logic sck,
  output logic csN,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdoOe
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    sdi = 1'b1;
  end

  // ----------------------------------------
  // one frame of nf falling edges, 80 ns clock
  // ----------------------------------------
  // hi leaves the clock high at select to provoke a framing error
  task automatic xfer(input logic [15:0] tx, input int nf, input bit hi,
                      output logic [15:0] rx, output logic [15:0] oe);
    int k;
    rx = 16'h0000;
    oe = 16'h0000;
    // odd offset keeps the link out of phase with the system clock
    #37;
    sck = hi;
    #40;
    csN = 1'b0;
    #40;
    for (k = 0; k < nf; k++) begin
      if (k > 0 || !hi) begin
        sck = 1'b1;
      end
      sdi = tx[15 - (k % 16)];
      #40;
      if (k < 16) begin
        rx[15 - k] = sdo;
        oe[15 - k] = sdoOe;
      end
      sck = 1'b0;
      #40;
    end
    csN = 1'b1;
    // released line must not keep showing the last bit
    sdi = ~sdi;
    #400;
  endtask
endmodule

/* dv/bridge_fault_diag_spi_tb.sv */
// self-checking bench for the bridge fault diagnosis block
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module bridge_fault_diag_spi_tb;
  localparam logic [7:0] ID_V = 8'h3c;   // arbitrary value
  localparam logic [7:0] REV_V = 8'h07;  // arbitrary value
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic modePin = 1'b1;
  logic outOn = 1'b1;
  logic outOff = 1'b0;
  logic uv = 1'b0;
  logic hs = 1'b0;
  logic ls = 1'b0;
  logic [2:0] det = 3'h0;
  logic sck, csN, sdi, sdo, sdoOe;
  logic faultFlagOut, faultFlagOe, outputsTristate, loadShortFlag;
  logic overTemperatureFlag, underVoltFlag, transferErrorFlag;
  logic [7:0] faultRegister;
  logic [7:0] expFault = 8'hff;
  logic expErr = 1'b0;
  logic [15:0] rx, oe;
  logic [31:0] seed = 32'hc95c67fe;
  logic [4:0] c;
  int err_total = 0;
  int checks = 0;
  int i;

  always #20 clk = ~clk;

  bfd_fault_diag #(.ID_CODE(ID_V), .REV_CODE(REV_V)) i_dut (
    .clk(clk), .nrst(nrst), .sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe),
    .diagModeSelectPin(modePin), .outputOnInput(outOn), .outputOffInput(outOff),
    .underVoltDet(uv), .overTempDet(det[2]), .tempCurrRedDet(det[1]),
    .currLimitDet(det[0]), .overCurrDet(1'b0), .openLoadDet(1'b0), .hsShortDet(hs),
    .lsShortDet(ls), .shortGndDet(2'h0), .shortBatDet(2'h0), .faultFlagOut(faultFlagOut),
    .faultFlagOe(faultFlagOe), .outputsTristate(outputsTristate),
    .loadShortFlag(loadShortFlag), .overTemperatureFlag(overTemperatureFlag),
    .underVoltFlag(underVoltFlag), .transferErrorFlag(transferErrorFlag),
    .faultRegister(faultRegister)
  );

  bfd_spi_master i_master (.sck(sck), .csN(csN), .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe));

  task automatic wrap_up;
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------
  // frame plus reference model of the reply
  // ----------------------------------------
  task automatic frame(input logic [7:0] ins, input int nf, input bit hi);
    logic [7:0] data;
    logic [4:0] cd;
    bit match, valid, bad;
    cd = ins[5:1];
    match = (ins[7:6] == 2'b00);
    valid = (cd == 5'h00 || cd == 5'h01 || cd == 5'h04) && (ins[0] == ^cd);
    data = !valid ? 8'hff : (cd == 5'h00) ? ID_V : (cd == 5'h01) ? REV_V : expFault;
    // second byte is random and must not matter
    i_master.xfer({ins, 8'($random(seed))}, nf, hi, rx, oe);
    if (match && nf == 16 && !hi) begin
      `CHK(oe, 16'h3fff)
      `CHK(rx[13:0], {5'h15, expErr, data})
    end
    if (!match) begin
      `CHK(oe, 16'h0000)
    end
    bad = match && (!valid || nf != 16 || hi);
    if (bad) begin
      expErr = 1'b1;
    end else if (match && nf >= 8) begin
      expErr = 1'b0;
    end
    if (match && valid && cd == 5'h04 && nf == 16 && !hi) begin
      expFault = 8'hff;
    end
    `CHK(transferErrorFlag, expErr)
    `CHK(faultRegister, expFault)
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    #1;
    nrst = 1'b1;
    step(10);
    `CHK(faultRegister, 8'hff)
    `CHK(transferErrorFlag, 1'b0)
    `CHK(faultFlagOut, 1'b0)
    frame(8'h00, 16, 0);
    frame(8'h03, 16, 0);
    frame(8'h09, 16, 0);
    for (i = 0; i < 4; i++) begin
      c = 5'($random(seed));
      if (c == 5'h00 || c == 5'h01 || c == 5'h04) begin
        c = 5'h1f;
      end
      frame({2'b00, c, ^c}, 16, 0);
    end
    frame(8'h00, 16, 0);
    frame(8'h01, 16, 0);
    frame(8'h00, 16, 0);
    frame(8'h00, 12, 0);
    frame(8'h80, 16, 0);
    frame(8'h00, 16, 0);
    frame(8'h00, 17, 0);
    frame(8'h00, 16, 1);
    frame(8'h00, 16, 0);
    frame(8'h40, 16, 0);
    frame(8'hc9, 16, 0);
    // latched report bits, each cleared by a full read
    for (i = 0; i < 3; i++) begin
      det = 3'h4 >> i;
      step(8);
      det = 3'h0;
      step(8);
      if (i == 0) begin
        `CHK(overTemperatureFlag, 1'b1)
      end
      expFault = ~(8'h40 >> i);
      `CHK(faultRegister, expFault)
      frame(8'h09, 16, 0);
    end
    hs = 1'b1;
    step(20);
    ls = 1'b1;
    step(8);
    hs = 1'b0;
    ls = 1'b0;
    step(4);
    `CHK(loadShortFlag, 1'b1)
    expFault = 8'hfc;
    `CHK(faultRegister, expFault)
    outOn = 1'b0;
    step(8);
    `CHK(faultRegister[7], 1'b0)
    outOn = 1'b1;
    step(8);
    expFault = 8'hff;
    `CHK(faultRegister, expFault)
    // low side first: the other arrival order must flag as well
    ls = 1'b1;
    step(20);
    hs = 1'b1;
    step(8);
    hs = 1'b0;
    ls = 1'b0;
    step(4);
    `CHK(loadShortFlag, 1'b1)
    expFault = 8'hfc;
    `CHK(faultRegister, expFault)
    outOff = 1'b1;
    step(8);
    outOff = 1'b0;
    step(8);
    expFault = 8'hff;
    `CHK(faultRegister, expFault)
    `CHK(loadShortFlag, 1'b0)
    // flag mode
    modePin = 1'b0;
    step(8);
    `CHK(faultFlagOe, 1'b0)
    outOn = 1'b0;
    step(8);
    `CHK(faultFlagOe, 1'b1)
    outOn = 1'b1;
    outOff = 1'b1;
    step(8);
    `CHK(faultFlagOe, 1'b1)
    outOff = 1'b0;
    det = 3'h4;
    step(8);
    det = 3'h0;
    step(8);
    `CHK(faultFlagOe, 1'b1)
    `CHK(outputsTristate, 1'b1)
    outOff = 1'b1;
    step(8);
    outOff = 1'b0;
    step(8);
    `CHK(faultFlagOe, 1'b0)
    `CHK(outputsTristate, 1'b0)
    det = 3'h4;
    step(8);
    det = 3'h0;
    uv = 1'b1;
    step(8);
    `CHK(underVoltFlag, 1'b1)
    `CHK(outputsTristate, 1'b1)
    `CHK(faultFlagOe, 1'b1)
    uv = 1'b0;
    step(8);
    `CHK(faultFlagOe, 1'b0)
    `CHK(outputsTristate, 1'b0)
    // back to serial mode, error flag starts clear
    modePin = 1'b1;
    expErr = 1'b0;
    step(8);
    frame(8'h00, 16, 0);
    wrap_up();
  end

  // watchdog, run needs well under 200 us
  initial begin
    #500000;
    err_total++;
    wrap_up();
  end
endmodule
